//--- inc/dddc_pkg.sv
// Shared constants, field layouts and carrier types of the dual converter data control block.
// Assumes one clock domain; register indices are word indices, byte address is four times the index.
package dddc_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int DBG_W = 8;

  // Register indices (byte address is the index times four)
  localparam logic [5:0] IDX_CH0_SET = 6'h0c;
  localparam logic [5:0] IDX_CH1_SET = 6'h0e;
  localparam logic [5:0] IDX_CH0_OUT = 6'h10;
  localparam logic [5:0] IDX_CH1_OUT = 6'h12;
  localparam logic [5:0] IDX_CH0_STG = 6'h14;
  localparam logic [5:0] IDX_CH1_STG = 6'h16;
  localparam logic [5:0] IDX_DBG = 6'h18;
  localparam logic [5:0] IDX_BUSY = 6'h1a;
  localparam logic [5:0] IDX_STRIDE = 6'h02;

  // Reset values and writable-bit masks
  localparam logic [15:0] SET_RST = 16'h0000;
  localparam logic [15:0] SET_WMASK = 16'h0fcf;
  localparam logic [15:0] CODE_RST = 16'h0000;
  localparam logic [7:0] DBG_RST = 8'h00;
  localparam int DBG_RUN_BIT = 0;

  // Code placement inside the 16-bit data word
  localparam int CODE_W = 12;
  localparam int DITH_W = 4;
  localparam int LEFT_MSB = 15;
  localparam int LEFT_LSB = 4;
  localparam int RIGHT_MSB = 11;
  localparam int RIGHT_LSB = 0;
  localparam int DITH_MSB = 3;

  // Output current range codes
  localparam logic [1:0] CUR_LOW = 2'h0;
  localparam logic [1:0] CUR_MID = 2'h1;
  localparam logic [1:0] CUR_HIGH = 2'h2;
  localparam logic [1:0] CUR_RSVD = 2'h3;

  // Bit positions in the synchronization-busy status word
  localparam int BUSY_OUT_LSB = 2;
  localparam int BUSY_STG_LSB = 4;

  // Cycles a register write needs to cross into the converter side
  localparam int SYNC_CYCLES_DEF = 3;

  // Channel settings word, most significant field first
  typedef struct packed {
    logic [3:0] rsv_hi;
    logic [3:0] refresh;
    logic dither;
    logic keep_running_in_sleep;
    logic [1:0] rsv_mid;
    logic [1:0] output_current_range;
    logic enable;
    logic code_alignment_select;
  } dddc_settings_t;

  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dddc_req_t;

  // What one channel hands to its analog converter
  typedef struct packed {
    logic active;
    logic [1:0] output_current_range;
    logic [CODE_W-1:0] code;
    logic [DITH_W-1:0] dither;
  } dddc_conv_t;

  // Debug halt sequencing, Gray coded
  typedef enum logic [1:0] {
    HS_RUN = 2'b00,
    HS_DRAIN = 2'b01,
    HS_HALT = 2'b11
  } dddc_halt_t;

endpackage : dddc_pkg

//--- src/dddc_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes async_i comes from outside core_clk_i; output moves only when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module dddc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] sync_ff;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      meta_ff <= async_i;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
    end
  end

  // Bits that disagree hold, so a one-cycle glitch never passes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= (sync_ff & (s2_ff ^ s3_ff)) | (s3_ff & ~(s2_ff ^ s3_ff));
    end
  end

  assign sync_o = sync_ff;
endmodule : dddc_sync
`default_nettype wire

//--- src/dddc_wsync_reg.sv
// One write-synchronized register: pending copy, busy flag, commit after a fixed crossing delay.
// Assumes writes and loads come from logic on core_clk_i; swrst_i clears it like reset.
`timescale 1ns/1ps
`default_nettype none
module dddc_wsync_reg #(
  parameter int W = 16,
  parameter int SYNC = 3,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic swrst_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic load_i,
  input wire logic [W-1:0] load_data_i,
  output logic [W-1:0] value_o,
  output logic busy_o
);
  localparam int CNT_W = $clog2(SYNC + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SYNC);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(1);

  logic [CNT_W-1:0] cnt_ff;
  logic [W-1:0] pend_ff;
  logic [W-1:0] val_ff;
  logic busy_ff;
  logic commit;

  assign commit = busy_ff && (cnt_ff == CNT_LAST) && !wr_i;

  // Busy: a new write wins over the end of the previous crossing
  always_ff @(posedge core_clk_i) begin
    if (srst_i || swrst_i) begin
      busy_ff <= 1'b0;
      cnt_ff <= '0;
    end else if (wr_i) begin
      busy_ff <= 1'b1;
      cnt_ff <= CNT_LOAD;
    end else if (busy_ff) begin
      busy_ff <= (cnt_ff != CNT_LAST);
      cnt_ff <= cnt_ff - CNT_LAST;
    end
  end

  // Pending copy; the latest write is the one that commits
  always_ff @(posedge core_clk_i) begin
    if (srst_i || swrst_i) begin
      pend_ff <= RST;
    end else if (wr_i) begin
      pend_ff <= wdata_i;
    end
  end

  // Effective value; a committing write wins over a load in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i || swrst_i) begin
      val_ff <= RST;
    end else if (commit) begin
      val_ff <= pend_ff;
    end else if (load_i) begin
      val_ff <= load_data_i;
    end
  end

  assign value_o = val_ff;
  assign busy_o = busy_ff;

  // Helper: length of the current busy stretch
  logic [7:0] busy_len_ff;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || swrst_i || wr_i) begin
      busy_len_ff <= '0;
    end else if (busy_ff) begin
      busy_len_ff <= busy_len_ff + 8'h01;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i || swrst_i);

  AST_WSYNC_BUSY_LEN: assert property ($fell(busy_ff) |-> busy_len_ff == 8'(SYNC))
    else $error("busy stretch differs from crossing delay");
  AST_WSYNC_SET: assert property (wr_i |=> busy_ff)
    else $error("write did not raise busy");
  AST_WSYNC_COMMIT: assert property ($fell(busy_ff) |-> val_ff == $past(pend_ff))
    else $error("busy cleared without committing");
endmodule : dddc_wsync_reg
`default_nettype wire

//--- src/dddc_top.sv
// Register file and data path of a two-channel 12-bit converter controller.
// Assumes a single core clock; start events, standby, debug halt and conversion busy are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none
module dddc_top #(
  parameter int SYNC_CYCLES = dddc_pkg::SYNC_CYCLES_DEF
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic swrst_i,
  input wire logic ctrl_enable_i,
  input wire logic wr_guard_i,
  input wire dddc_pkg::dddc_req_t bus_req_i,
  output logic [dddc_pkg::DATA_W-1:0] rdata_o,
  input wire logic [1:0] load_evt_i,
  input wire logic standby_i,
  input wire logic dbg_halt_i,
  input wire logic conv_busy_i,
  output var dddc_pkg::dddc_conv_t [1:0] conv_o,
  output logic halted_o
);
  import dddc_pkg::*;

  localparam int NCH = 2;
  localparam int HALT_EXIT_MAX = 2;

  // Address decode; only word-aligned accesses hit a register
  logic [5:0] idx;
  logic aligned;
  logic wr_hit;
  logic rd_hit;
  assign idx = bus_req_i.addr[ADDR_W-1:2];
  assign aligned = (bus_req_i.addr[1:0] == 2'b00);
  assign wr_hit = bus_req_i.wr && aligned;
  assign rd_hit = bus_req_i.rd && aligned;

  // Asynchronous pins through the three-stage filter
  logic [4:0] async_s;
  logic cbusy_s;
  logic dbg_s;
  logic stby_s;
  logic [1:0] evt_s;
  dddc_sync #(.W(5)) u_pin_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i({conv_busy_i, dbg_halt_i, standby_i, load_evt_i}),
    .sync_o(async_s)
  );
  assign {cbusy_s, dbg_s, stby_s, evt_s} = async_s;

  // Debug control; only a hard reset clears it
  logic [DBG_W-1:0] dbg_ff;
  logic dbg_run;
  assign dbg_run = dbg_ff[DBG_RUN_BIT];
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      dbg_ff <= DBG_RST;
    end else if (wr_hit && (idx == IDX_DBG) && !wr_guard_i) begin
      dbg_ff <= {{(DBG_W-1){1'b0}}, bus_req_i.wdata[DBG_RUN_BIT]};
    end
  end

  // Debug halt sequencing: drain a running conversion before freezing
  dddc_halt_t halt_st_ff;
  dddc_halt_t nxt_halt_st;
  logic halt_req;
  assign halt_req = dbg_s && !dbg_run;
  always_comb begin
    nxt_halt_st = halt_st_ff;
    unique case (halt_st_ff)
      HS_RUN: begin
        if (halt_req) begin
          nxt_halt_st = cbusy_s ? HS_DRAIN : HS_HALT;
        end
      end
      HS_DRAIN: begin
        if (!halt_req) begin
          nxt_halt_st = HS_RUN;
        end else if (!cbusy_s) begin
          nxt_halt_st = HS_HALT;
        end
      end
      HS_HALT: begin
        if (!halt_req) begin
          nxt_halt_st = HS_RUN;
        end
      end
      default: begin
        nxt_halt_st = HS_RUN;
      end
    endcase
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      halt_st_ff <= HS_RUN;
    end else begin
      halt_st_ff <= nxt_halt_st;
    end
  end
  assign halted_o = (halt_st_ff == HS_HALT);

  // Start events: edge of the filtered level, one pulse each, dropped while halted
  logic [1:0] evt_prev_ff;
  logic [1:0] load_pulse;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      evt_prev_ff <= 2'b00;
    end else begin
      evt_prev_ff <= evt_s;
    end
  end
  assign load_pulse = evt_s & ~evt_prev_ff & {NCH{!halted_o}};

  // Per-channel storage and conversion word
  dddc_settings_t [NCH-1:0] set_ff;
  logic [NCH-1:0] wr_set;
  logic [NCH-1:0] wr_out;
  logic [NCH-1:0] wr_stg;
  logic [NCH-1:0] out_busy;
  logic [NCH-1:0] stg_busy;
  logic [NCH-1:0][REG_W-1:0] out_val;
  logic [NCH-1:0][REG_W-1:0] stg_val;
  dddc_conv_t [NCH-1:0] conv_ff;
  dddc_conv_t [NCH-1:0] nxt_conv;

  for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
    localparam logic [5:0] SET_IDX = IDX_CH0_SET + IDX_STRIDE * 6'(ch);
    localparam logic [5:0] OUT_IDX = IDX_CH0_OUT + IDX_STRIDE * 6'(ch);
    localparam logic [5:0] STG_IDX = IDX_CH0_STG + IDX_STRIDE * 6'(ch);

    // Settings are guarded and cannot change while the controller is enabled
    assign wr_set[ch] = wr_hit && (idx == SET_IDX) && !wr_guard_i && !ctrl_enable_i;
    assign wr_out[ch] = wr_hit && (idx == OUT_IDX) && !wr_guard_i;
    assign wr_stg[ch] = wr_hit && (idx == STG_IDX);

    always_ff @(posedge core_clk_i) begin
      if (srst_i || swrst_i) begin
        set_ff[ch] <= dddc_settings_t'(SET_RST);
      end else if (wr_set[ch]) begin
        set_ff[ch] <= dddc_settings_t'(bus_req_i.wdata[REG_W-1:0] & SET_WMASK);
      end
    end

    // Staged code: written by software, no guard
    dddc_wsync_reg #(.W(REG_W), .SYNC(SYNC_CYCLES), .RST(CODE_RST)) u_stg (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .swrst_i(swrst_i),
      .wr_i(wr_stg[ch]),
      .wdata_i(bus_req_i.wdata[REG_W-1:0]),
      .load_i(1'b0),
      .load_data_i(CODE_RST),
      .value_o(stg_val[ch]),
      .busy_o(stg_busy[ch])
    );

    // Output code: written by software or loaded from the staged code
    dddc_wsync_reg #(.W(REG_W), .SYNC(SYNC_CYCLES), .RST(CODE_RST)) u_out (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .swrst_i(swrst_i),
      .wr_i(wr_out[ch]),
      .wdata_i(bus_req_i.wdata[REG_W-1:0]),
      .load_i(load_pulse[ch]),
      .load_data_i(stg_val[ch]),
      .value_o(out_val[ch]),
      .busy_o(out_busy[ch])
    );

    // Conversion word; the code freezes while halted
    always_comb begin
      nxt_conv[ch] = conv_ff[ch];
      nxt_conv[ch].output_current_range = set_ff[ch].output_current_range;
      nxt_conv[ch].active = set_ff[ch].enable && ctrl_enable_i
        && !(stby_s && !set_ff[ch].keep_running_in_sleep)
        && !halted_o;
      if (!halted_o) begin
        if (set_ff[ch].dither) begin
          nxt_conv[ch].code = out_val[ch][LEFT_MSB:LEFT_LSB];
          nxt_conv[ch].dither = out_val[ch][DITH_MSB:0];
        end else if (set_ff[ch].code_alignment_select) begin
          nxt_conv[ch].code = out_val[ch][LEFT_MSB:LEFT_LSB];
          nxt_conv[ch].dither = '0;
        end else begin
          nxt_conv[ch].code = out_val[ch][RIGHT_MSB:RIGHT_LSB];
          nxt_conv[ch].dither = '0;
        end
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
        conv_ff[ch] <= '0;
      end else begin
        conv_ff[ch] <= nxt_conv[ch];
      end
    end
  end

  assign conv_o = conv_ff;

  // Read port: data stand only in the cycle after the strobe
  logic [DATA_W-1:0] rdata_ff;
  always_ff @(posedge core_clk_i) begin
    if (srst_i || !rd_hit) begin
      rdata_ff <= '0;
    end else begin
      case (idx)
        IDX_CH0_SET: rdata_ff <= {16'h0000, set_ff[0]};
        IDX_CH1_SET: rdata_ff <= {16'h0000, set_ff[1]};
        IDX_DBG: rdata_ff <= {24'h000000, dbg_ff};
        IDX_BUSY: rdata_ff <= {26'h0000000, stg_busy, out_busy, 2'b00};
        default: rdata_ff <= '0;
      endcase
    end
  end
  assign rdata_o = rdata_ff;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  AST_STBY_STOP: assert property ((stby_s && !set_ff[1].keep_running_in_sleep) |=> !conv_o[1].active)
    else $error("channel 1 active in standby without keep-running");
  AST_STBY_KEEP: assert property ((stby_s && set_ff[1].keep_running_in_sleep && set_ff[1].enable
    && ctrl_enable_i && !halted_o) |=> conv_o[1].active)
    else $error("channel 1 stopped in standby despite keep-running");
  AST_RANGE: assert property (1'b1 |=> conv_o[1].output_current_range == $past(set_ff[1].output_current_range))
    else $error("current range does not follow setting");
  AST_ENABLE: assert property (!(set_ff[1].enable && ctrl_enable_i) |=> !conv_o[1].active)
    else $error("channel 1 active without both enables");
  AST_RIGHT: assert property ((!halted_o && !set_ff[0].dither && !set_ff[0].code_alignment_select)
    |=> conv_o[0].code == $past(out_val[0][RIGHT_MSB:RIGHT_LSB]))
    else $error("right-adjusted code wrong");
  AST_LEFT: assert property ((!halted_o && !set_ff[1].dither && set_ff[1].code_alignment_select)
    |=> conv_o[1].code == $past(out_val[1][LEFT_MSB:LEFT_LSB]) && conv_o[1].dither == '0)
    else $error("left-adjusted code wrong");
  AST_DITHER: assert property ((!halted_o && set_ff[0].dither)
    |=> conv_o[0].code == $past(out_val[0][LEFT_MSB:LEFT_LSB]) && conv_o[0].dither == $past(out_val[0][DITH_MSB:0]))
    else $error("dithering split wrong");
  AST_DITH_OFF: assert property ((!halted_o && !set_ff[1].dither) |=> conv_o[1].dither == '0)
    else $error("dither bits present with dithering off");
  AST_WO_READ: assert property ((rd_hit && (idx == IDX_CH0_OUT || idx == IDX_CH1_STG)) |=> rdata_o == '0)
    else $error("write-only register read back nonzero");
  AST_LOAD: assert property ((load_pulse[1] && !out_busy[1]) |=> out_val[1] == $past(stg_val[1]))
    else $error("start event did not copy staged code");
  AST_GUARD_OUT: assert property ((wr_hit && idx == IDX_CH0_OUT && wr_guard_i && !out_busy[0]) |=> !out_busy[0])
    else $error("guarded output code write accepted");
  AST_GUARD_STG: assert property ((wr_hit && idx == IDX_CH0_STG && wr_guard_i) |=> stg_busy[0])
    else $error("staged code write wrongly blocked");
  AST_DBG_KEEP: assert property ((swrst_i && !(wr_hit && idx == IDX_DBG)) |=> dbg_ff == $past(dbg_ff))
    else $error("debug-run lost on software reset");
  AST_HALT_ENTER: assert property ((halt_req && !cbusy_s && halt_st_ff != HS_HALT) |=> halted_o)
    else $error("halt not entered after conversion done");
  AST_HALT_WAIT: assert property ((halt_st_ff == HS_RUN && halt_req && cbusy_s) |=> !halted_o)
    else $error("halted during ongoing conversion");
  AST_HALT_EXIT: assert property ((halted_o && !halt_req) |-> ##[1:HALT_EXIT_MAX] !halted_o)
    else $error("halt not released");
  AST_ONE_PULSE: assert property (load_pulse[0] |=> !load_pulse[0])
    else $error("start event gave more than one transfer");

  COV_LOAD1: cover property (load_pulse[1] ##1 out_val[1] == stg_val[1]);
  COV_DITHER: cover property (set_ff[0].dither && conv_o[0].dither != '0);
  COV_HALT_DRAIN: cover property (halt_st_ff == HS_DRAIN ##1 halted_o);
  COV_BUSY_READ: cover property (rd_hit && idx == IDX_BUSY ##1 rdata_o != '0);
endmodule : dddc_top
`default_nettype wire

//--- verification/dddc_top_tb_top.sv
// Self-checking bench for the dual converter data control block: table loop, then hand-written cases.
// Assumes the block's package is compiled first; the bench drives every port itself, no partner model.
`timescale 1ns/1ps
`default_nettype none
module dddc_top_tb_top;
  import dddc_pkg::*;

  localparam int SYNC = 3;
  // One table row: channel, settings word, data word, expected code and dither
  typedef struct packed {
    logic ch;
    logic [15:0] set;
    logic [15:0] data;
    logic [11:0] code;
    logic [3:0] dith;
  } dddc_row_t;

  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic swrst_i = 1'b0;
  logic ctrl_enable_i = 1'b0;
  logic wr_guard_i = 1'b0;
  dddc_req_t req = '0;
  logic [DATA_W-1:0] rdata_o;
  logic [1:0] load_evt_i = 2'h0;
  logic standby_i = 1'b0;
  logic dbg_halt_i = 1'b0;
  logic conv_busy_i = 1'b0;
  dddc_conv_t [1:0] conv_o;
  logic halted_o;
  int miscompares = 0;
  int checked = 0;
  // Reserved bits set in the last row so the readback mask is exercised
  dddc_row_t rows [7] = '{
    '{1'b0, 16'h0002, 16'hfabc, 12'habc, 4'h0},
    '{1'b0, 16'h0007, 16'habcd, 12'habc, 4'h0},
    '{1'b1, 16'h0089, 16'h1235, 12'h123, 4'h5},
    '{1'b1, 16'h008e, 16'h9876, 12'h987, 4'h6},
    '{1'b0, 16'h0080, 16'hbeef, 12'hbee, 4'hf},
    '{1'b1, 16'h0001, 16'hc3a7, 12'hc3a, 4'h0},
    '{1'b0, 16'hff7e, 16'h0fff, 12'hfff, 4'h0}
  };

  dddc_top #(.SYNC_CYCLES(SYNC)) dddc_top_i (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .swrst_i(swrst_i),
    .ctrl_enable_i(ctrl_enable_i),
    .wr_guard_i(wr_guard_i),
    .bus_req_i(req),
    .rdata_o(rdata_o),
    .load_evt_i(load_evt_i),
    .standby_i(standby_i),
    .dbg_halt_i(dbg_halt_i),
    .conv_busy_i(conv_busy_i),
    .conv_o(conv_o),
    .halted_o(halted_o)
  );

  // 10 MHz core clock
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  // Every task leaves at a falling edge, so outputs are settled when looked at
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : tick

  // A gap cycle follows each write so no strobe is assigned twice in one step
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    req.addr <= a;
    req.wdata <= {16'h0000, d};
    req.wr <= 1'b1;
    @(posedge core_clk_i);
    req.wr <= 1'b0;
    @(negedge core_clk_i);
  endtask : bus_wr

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge core_clk_i);
    req.rd <= 1'b0;
    @(negedge core_clk_i);
    check(rdata_o, exp);
  endtask : bus_rd

  // Watchdog sized well above the longest expected run
  initial begin
    repeat (6000) @(posedge core_clk_i);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    logic [7:0] sa;
    repeat (3) @(posedge core_clk_i);
    srst_i <= 1'b0;
    tick(4);
    // Reset values
    check(conv_o[0], '0);
    check(conv_o[1], '0);
    check(halted_o, 1'b0);
    bus_rd(8'h30, 32'h0);
    bus_rd(8'h60, 32'h0);
    bus_rd(8'h68, 32'h0);
    // Table of settings and data words, both channels
    foreach (rows[i]) begin
      sa = 8'h30 + {4'h0, rows[i].ch, 3'h0};
      bus_wr(sa, rows[i].set);
      bus_rd(sa, {16'h0, rows[i].set & SET_WMASK});
      bus_wr(sa + 8'h10, rows[i].data);
      tick(SYNC + 3);
      check(conv_o[rows[i].ch].active, 1'b0);
      check(conv_o[rows[i].ch].code, rows[i].code);
      check(conv_o[rows[i].ch].output_current_range, rows[i].set[3:2]);
      check(conv_o[rows[i].ch].dither, rows[i].dith);
      @(posedge core_clk_i);
      ctrl_enable_i <= 1'b1;
      tick(2);
      check(conv_o[rows[i].ch].active, rows[i].set[1]);
      @(posedge core_clk_i);
      ctrl_enable_i <= 1'b0;
      tick(2);
    end
    // Channel 0 output code reads back as zero; unmapped place reads zero
    bus_rd(8'h40, 32'h0);
    bus_rd(8'h7c, 32'h0);
    // Busy flag rises on a staged write and falls after the crossing
    bus_wr(8'h50, 16'h0321);
    bus_rd(8'h68, 32'h10);
    tick(SYNC + 1);
    bus_rd(8'h68, 32'h0);
    // Guard drops output-code writes but lets staged writes through
    @(posedge core_clk_i);
    wr_guard_i <= 1'b1;
    bus_wr(8'h40, 16'h0111);
    bus_rd(8'h68, 32'h0);
    bus_wr(8'h58, 16'h0456);
    bus_rd(8'h68, 32'h20);
    tick(SYNC + 3);
    check(conv_o[0].code, 12'hfff);
    @(posedge core_clk_i);
    wr_guard_i <= 1'b0;
    // A held start level moves the staged code once
    bus_wr(8'h38, 16'h0002);
    @(posedge core_clk_i);
    load_evt_i[1] <= 1'b1;
    tick(8);
    check(conv_o[1].code, 12'h456);
    bus_wr(8'h58, 16'h0789);
    tick(SYNC + 6);
    check(conv_o[1].code, 12'h456);
    @(posedge core_clk_i);
    load_evt_i[1] <= 1'b0;
    tick(4);
    @(posedge core_clk_i);
    load_evt_i[1] <= 1'b1;
    tick(8);
    check(conv_o[1].code, 12'h789);
    check(conv_o[0].code, 12'hfff);
    // Channel 0 event moves its own staged code
    @(posedge core_clk_i);
    load_evt_i[0] <= 1'b1;
    tick(8);
    check(conv_o[0].code, 12'h321);
    // Standby stops channel 1 unless kept running
    @(posedge core_clk_i);
    ctrl_enable_i <= 1'b1;
    standby_i <= 1'b1;
    tick(6);
    check(conv_o[1].active, 1'b0);
    @(posedge core_clk_i);
    standby_i <= 1'b0;
    ctrl_enable_i <= 1'b0;
    bus_wr(8'h38, 16'h0042);
    @(posedge core_clk_i);
    ctrl_enable_i <= 1'b1;
    standby_i <= 1'b1;
    tick(6);
    check(conv_o[1].active, 1'b1);
    @(posedge core_clk_i);
    standby_i <= 1'b0;
    ctrl_enable_i <= 1'b0;
    // Software reset clears settings but keeps the debug-run bit
    bus_wr(8'h60, 16'h0001);
    @(posedge core_clk_i);
    swrst_i <= 1'b1;
    @(posedge core_clk_i);
    swrst_i <= 1'b0;
    tick(1);
    bus_rd(8'h60, 32'h1);
    bus_rd(8'h38, 32'h0);
    bus_wr(8'h38, 16'h0002);
    // Debug halt: ignored with run bit set, waits for conversion otherwise
    @(posedge core_clk_i);
    ctrl_enable_i <= 1'b1;
    dbg_halt_i <= 1'b1;
    conv_busy_i <= 1'b1;
    tick(8);
    check(halted_o, 1'b0);
    bus_wr(8'h60, 16'h0000);
    tick(8);
    check(halted_o, 1'b0);
    check(conv_o[1].active, 1'b1);
    @(posedge core_clk_i);
    conv_busy_i <= 1'b0;
    tick(8);
    check(halted_o, 1'b1);
    check(conv_o[1].active, 1'b0);
    @(posedge core_clk_i);
    dbg_halt_i <= 1'b0;
    tick(8);
    check(halted_o, 1'b0);
    check(conv_o[1].active, 1'b1);
    // Settings cannot change while the controller is enabled
    bus_wr(8'h38, 16'h0000);
    bus_rd(8'h38, 32'h2);
    // Mid-run hard reset clears settings, codes and the debug-run bit
    bus_wr(8'h60, 16'h0001);
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    tick(3);
    @(posedge core_clk_i);
    srst_i <= 1'b0;
    tick(4);
    check(conv_o[0], '0);
    check(conv_o[1], '0);
    check(halted_o, 1'b0);
    bus_rd(8'h60, 32'h0);
    tally_and_finish();
  end
endmodule : dddc_top_tb_top
`default_nettype wire
